// >>> ipac_checker.sv
// Port access checker: privilege test, bitmap test and port ordering
//
// Local design decisions: the strobed register port and the register addresses.
`include "ipac_defines.svh"

module ipac_checker
    import ipac_pkg::*;
(
    input wire logic clock,             // 50 MHz clock
    input wire logic arst_n,            // Async reset, active low
    input wire logic [7:0] reg_addr,    // Register byte address
    input wire logic [31:0] reg_wdata,  // Register write data
    input wire logic reg_wr,            // Register write strobe
    input wire logic reg_rd,            // Register read strobe
    output logic [31:0] reg_rdata,      // Read data, cycle after strobe
    input wire logic req_valid,         // Core offers an operation
    input wire ipac_req_t req,          // Operation details
    output logic req_ready,             // Checker idle, takes req
    output logic rsp_valid,             // Operation finished pulse
    output logic rsp_fault,             // Protection fault with rsp
    output logic [31:0] rsp_rdata,      // Port read data with rsp
    input wire logic store_pending,     // Core store buffer not empty
    output logic tss_rd_req,            // Bitmap fetch pulse
    output logic [31:0] tss_rd_addr,    // Bitmap first byte offset
    input wire logic tss_rd_valid,      // Bitmap bytes returned
    input wire logic [15:0] tss_rd_data,// Two bytes, first byte low
    output ipac_io_t io,                // Port cycle to external bus
    input wire logic io_done,           // Port cycle finished
    input wire logic [31:0] io_rdata,   // Port read data
    output logic irq_enable,            // Interrupt enable flag
    output logic legacy_mode            // Legacy virtual mode active
);

    typedef enum logic [2:0] {
        IPAC_IDLE,
        IPAC_DECIDE,
        IPAC_FETCH,
        IPAC_ORDER,
        IPAC_BUS
    } ipac_state_t;

    // ----------------------------------------
    // State
    // ----------------------------------------
    ipac_state_t state_r, state_nxt;
    ipac_req_t req_r, req_nxt;
    logic [31:0] flags_r, flags_nxt;
    logic ctrl_v86_r, ctrl_v86_nxt;
    logic [1:0] cpl_r, cpl_nxt;
    logic [15:0] base_r, base_nxt;
    logic [31:0] limit_r, limit_nxt;
    logic [15:0] fault_cnt_r, fault_cnt_nxt;
    logic last_fault_r, last_fault_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ready_r, ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic rsp_fault_r, rsp_fault_nxt;
    logic [31:0] rsp_rdata_r, rsp_rdata_nxt;
    logic tss_req_r, tss_req_nxt;
    logic [31:0] tss_addr_r, tss_addr_nxt;
    ipac_io_t io_r, io_nxt;

    // ----------------------------------------
    // Privilege and bitmap test
    // ----------------------------------------
    logic [1:0] priv_field;
    logic priv_ok;
    logic need_map;
    logic map_absent;
    logic is_port_op;
    logic is_port_rd;
    logic [15:0] window;
    logic map_hit;

    assign priv_field = flags_r[`IPAC_PRIV_HI:`IPAC_PRIV_LO];
    assign priv_ok = cpl_r <= priv_field;
    assign need_map = !priv_ok || ctrl_v86_r;
    assign map_absent = {16'h0000, base_r} >= limit_r;
    assign is_port_rd = req_r.op == IPAC_OP_PORT_RD
        || req_r.op == IPAC_OP_PORT_RD_STR;
    assign is_port_op = is_port_rd || req_r.op == IPAC_OP_PORT_WR
        || req_r.op == IPAC_OP_PORT_WR_STR;

    // Bytes past the limit read as all ones, which covers a map
    // missing its trailing byte as well
    always_comb begin
        window = tss_rd_data;
        if (tss_addr_r > limit_r) begin
            window[7:0] = `IPAC_BYTE_ONES;
        end
        if (tss_addr_r >= limit_r) begin
            window[15:8] = `IPAC_BYTE_ONES;
        end
    end

    ipac_bit_select u_bit_select (
        .window(window),
        .offs(req_r.port[2:0]),
        .width(req_r.width),
        .any_set(map_hit)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        flags_nxt = flags_r;
        ctrl_v86_nxt = ctrl_v86_r;
        cpl_nxt = cpl_r;
        base_nxt = base_r;
        limit_nxt = limit_r;
        fault_cnt_nxt = fault_cnt_r;
        last_fault_nxt = last_fault_r;
        rdata_nxt = 32'h0000_0000;
        ready_nxt = ready_r;
        rsp_valid_nxt = 1'b0;
        rsp_fault_nxt = 1'b0;
        rsp_rdata_nxt = rsp_rdata_r;
        tss_req_nxt = 1'b0;
        tss_addr_nxt = tss_addr_r;
        io_nxt = io_r;

        // Software side of the register file
        if (reg_wr) begin
            case (reg_addr)
                `IPAC_REG_CTRL: ctrl_v86_nxt = reg_wdata[`IPAC_CTRL_V86_BIT];
                `IPAC_REG_FLAGS: flags_nxt = reg_wdata;
                `IPAC_REG_CPL: cpl_nxt = reg_wdata[1:0];
                `IPAC_REG_MAP_BASE: base_nxt = reg_wdata[15:0];
                `IPAC_REG_SEG_LIMIT: limit_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `IPAC_REG_CTRL: rdata_nxt = {31'h0000_0000, ctrl_v86_r};
                `IPAC_REG_FLAGS: rdata_nxt = flags_r;
                `IPAC_REG_CPL: rdata_nxt = {30'h0000_0000, cpl_r};
                `IPAC_REG_MAP_BASE: rdata_nxt = {16'h0000, base_r};
                `IPAC_REG_SEG_LIMIT: rdata_nxt = limit_r;
                `IPAC_REG_STATUS: rdata_nxt = {fault_cnt_r, 14'h0000,
                    last_fault_r, !ready_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end

        case (state_r)
            IPAC_IDLE: begin
                if (req_valid) begin
                    req_nxt = req;
                    ready_nxt = 1'b0;
                    state_nxt = IPAC_DECIDE;
                end
            end
            IPAC_DECIDE: begin
                case (req_r.op)
                    IPAC_OP_PORT_RD, IPAC_OP_PORT_RD_STR,
                    IPAC_OP_PORT_WR, IPAC_OP_PORT_WR_STR: begin
                        if (!need_map) begin
                            state_nxt = IPAC_ORDER;
                        end else if (map_absent) begin
                            rsp_valid_nxt = 1'b1;
                            rsp_fault_nxt = 1'b1;
                            state_nxt = IPAC_IDLE;
                        end else begin
                            tss_req_nxt = 1'b1;
                            tss_addr_nxt = {16'h0000, base_r}
                                + {19'h00000, req_r.port[15:3]};
                            state_nxt = IPAC_FETCH;
                        end
                    end
                    IPAC_OP_IRQ_MASK, IPAC_OP_IRQ_UNMASK: begin
                        rsp_valid_nxt = 1'b1;
                        state_nxt = IPAC_IDLE;
                        if (!priv_ok) begin
                            rsp_fault_nxt = 1'b1;
                        end else begin
                            flags_nxt[`IPAC_IF_BIT] = req_r.op == IPAC_OP_IRQ_UNMASK;
                        end
                    end
                    IPAC_OP_FLAGS_POP, IPAC_OP_TRAP_RET: begin
                        // Protected fields keep their value; no fault
                        flags_nxt = req_r.flags_val;
                        if (cpl_r != 2'h0) begin
                            flags_nxt[`IPAC_PRIV_HI:`IPAC_PRIV_LO] =
                                priv_field;
                        end
                        if (req_r.op == IPAC_OP_FLAGS_POP && !priv_ok) begin
                            flags_nxt[`IPAC_IF_BIT] =
                                flags_r[`IPAC_IF_BIT];
                        end
                        rsp_valid_nxt = 1'b1;
                        state_nxt = IPAC_IDLE;
                    end
                    IPAC_OP_MEM_RD: begin
                        // Uncacheable reads never pass older stores;
                        // cacheable ones may, for speed
                        if (!(req_r.uncached && store_pending)) begin
                            rsp_valid_nxt = 1'b1;
                            state_nxt = IPAC_IDLE;
                        end
                    end
                    default: begin
                        rsp_valid_nxt = 1'b1;
                        state_nxt = IPAC_IDLE;
                    end
                endcase
            end
            IPAC_FETCH: begin
                if (tss_rd_valid) begin
                    if (map_hit) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_fault_nxt = 1'b1;
                        state_nxt = IPAC_IDLE;
                    end else begin
                        state_nxt = IPAC_ORDER;
                    end
                end
            end
            IPAC_ORDER: begin
                // Drain older stores before the port cycle goes out
                if (!store_pending) begin
                    io_nxt.valid = 1'b1;
                    io_nxt.write = !is_port_rd;
                    io_nxt.addr = req_r.port;
                    io_nxt.width = req_r.width;
                    io_nxt.wdata = req_r.wdata;
                    state_nxt = IPAC_BUS;
                end
            end
            IPAC_BUS: begin
                // Next op held off until the port cycle completes
                if (io_done) begin
                    io_nxt.valid = 1'b0;
                    rsp_valid_nxt = 1'b1;
                    if (is_port_rd) begin
                        rsp_rdata_nxt = io_rdata;
                    end
                    state_nxt = IPAC_IDLE;
                end
            end
            default: state_nxt = IPAC_IDLE;
        endcase

        if (rsp_valid_nxt) begin
            ready_nxt = 1'b1;
            last_fault_nxt = rsp_fault_nxt;
            if (rsp_fault_nxt) begin
                fault_cnt_nxt = fault_cnt_r + 16'h0001;
            end
        end
        if (is_port_op && state_r == IPAC_DECIDE && !need_map) begin
            ready_nxt = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= IPAC_IDLE;
            req_r <= '0;
            flags_r <= `IPAC_FLAGS_RESET;
            ctrl_v86_r <= 1'b0;
            cpl_r <= `IPAC_CPL_RESET;
            base_r <= `IPAC_BASE_RESET;
            limit_r <= `IPAC_LIMIT_RESET;
            fault_cnt_r <= 16'h0000;
            last_fault_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            ready_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_fault_r <= 1'b0;
            rsp_rdata_r <= 32'h0000_0000;
            tss_req_r <= 1'b0;
            tss_addr_r <= 32'h0000_0000;
            io_r <= '0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            flags_r <= flags_nxt;
            ctrl_v86_r <= ctrl_v86_nxt;
            cpl_r <= cpl_nxt;
            base_r <= base_nxt;
            limit_r <= limit_nxt;
            fault_cnt_r <= fault_cnt_nxt;
            last_fault_r <= last_fault_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_fault_r <= rsp_fault_nxt;
            rsp_rdata_r <= rsp_rdata_nxt;
            tss_req_r <= tss_req_nxt;
            tss_addr_r <= tss_addr_nxt;
            io_r <= io_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign req_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_fault = rsp_fault_r;
    assign rsp_rdata = rsp_rdata_r;
    assign tss_rd_req = tss_req_r;
    assign tss_rd_addr = tss_addr_r;
    assign io = io_r;
    assign irq_enable = flags_r[`IPAC_IF_BIT];
    assign legacy_mode = ctrl_v86_r;

endmodule

// >>> ipac_defines.svh
// Constants for the port access checker: offsets, fields, reset values
`ifndef IPAC_DEFINES_SVH
`define IPAC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IPAC_REG_CTRL 8'h00
`define IPAC_REG_FLAGS 8'h04
`define IPAC_REG_CPL 8'h08
`define IPAC_REG_MAP_BASE 8'h0C
`define IPAC_REG_SEG_LIMIT 8'h10
`define IPAC_REG_STATUS 8'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define IPAC_CTRL_V86_BIT 0
`define IPAC_PRIV_LO 12
`define IPAC_PRIV_HI 13
`define IPAC_IF_BIT 9
`define IPAC_FLAGS_RESET 32'h0000_0002
`define IPAC_LIMIT_RESET 32'h0000_0000
`define IPAC_BASE_RESET 16'hFFFF
`define IPAC_CPL_RESET 2'h0
`define IPAC_BYTE_ONES 8'hFF

`endif

// >>> ipac_pkg.sv
// Types shared by the port access checker
package ipac_pkg;

    typedef enum logic [3:0] {
        IPAC_OP_PORT_RD,
        IPAC_OP_PORT_RD_STR,
        IPAC_OP_PORT_WR,
        IPAC_OP_PORT_WR_STR,
        IPAC_OP_IRQ_MASK,
        IPAC_OP_IRQ_UNMASK,
        IPAC_OP_FLAGS_POP,
        IPAC_OP_TRAP_RET,
        IPAC_OP_MEM_RD,
        IPAC_OP_MEM_WR
    } ipac_op_t;

    // Byte, word, doubleword
    typedef enum logic [1:0] {
        IPAC_W1,
        IPAC_W2,
        IPAC_W4
    } ipac_width_t;

    typedef struct packed {
        ipac_op_t op;
        logic [15:0] port;
        ipac_width_t width;
        logic [31:0] wdata;
        logic [31:0] flags_val;
        logic uncached;
    } ipac_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        ipac_width_t width;
        logic [31:0] wdata;
    } ipac_io_t;

endpackage

// >>> ipac_bit_select.sv
// Bitmap window bit selection and test
module ipac_bit_select
    import ipac_pkg::*;
(
    input wire logic [15:0] window, // Two bitmap bytes, first byte low
    input wire logic [2:0] offs,    // Port address mod eight
    input wire ipac_width_t width,  // Access width
    output logic any_set            // A covered bit is set
);
    logic [15:0] shifted;
    logic [3:0] mask;

    always_comb begin
        shifted = window >> offs;
        case (width)
            IPAC_W1: mask = 4'h1;
            IPAC_W2: mask = 4'h3;
            IPAC_W4: mask = 4'hF;
            default: mask = 4'hF;
        endcase
        any_set = |(shifted[3:0] & mask);
    end
endmodule

// >>> ipac_checker_assertions.sv
// Concurrent checks on the port access checker's ports
module ipac_checker_assertions
    import ipac_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic arst_n, // Async reset, active low
    input wire logic reg_rd, // Register read strobe
    input wire logic [31:0] reg_rdata, // Register read data
    input wire logic req_valid, // Core offers op
    input wire ipac_req_t req, // Op details
    input wire logic req_ready, // Checker idle
    input wire logic rsp_valid, // Op finished
    input wire logic rsp_fault, // Protection fault
    input wire logic store_pending, // Stores outstanding
    input wire logic tss_rd_req, // Bitmap fetch
    input wire ipac_io_t io, // Port cycle
    input wire logic io_done, // Port cycle finished
    input wire logic irq_enable // Interrupt enable flag
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire logic take = req_valid && req_ready;
    property p_ready_drop; take |=> !req_ready; endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready kept after take");
    property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than one cycle");
    property p_simple_lat;
        take && (req.op inside {IPAC_OP_IRQ_MASK, IPAC_OP_IRQ_UNMASK, IPAC_OP_FLAGS_POP,
            IPAC_OP_TRAP_RET, IPAC_OP_MEM_WR} || (req.op == IPAC_OP_MEM_RD && !req.uncached))
            |-> ##2 rsp_valid;
    endproperty
    a_simple_lat: assert property (p_simple_lat) else $error("flag op latency wrong");
    property p_mask; take && req.op == IPAC_OP_IRQ_MASK |-> ##2 (rsp_fault || !irq_enable);
    endproperty
    a_mask: assert property (p_mask) else $error("mask op left flag set");
    property p_unmask; take && req.op == IPAC_OP_IRQ_UNMASK |-> ##2 (rsp_fault || irq_enable);
    endproperty
    a_unmask: assert property (p_unmask) else $error("unmask op left flag clear");
    property p_store_wait; $rose(io.valid) |-> !$past(store_pending); endproperty
    a_store_wait: assert property (p_store_wait) else $error("port cycle passed stores");
    property p_io_hold;
        io.valid && !io_done |=> io.valid && $stable(io.addr) && $stable(io.write);
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("port cycle changed early");
    property p_io_end; io.valid && io_done |=> !io.valid && rsp_valid && !rsp_fault; endproperty
    a_io_end: assert property (p_io_end) else $error("no response after port cycle");
    property p_fault_no_io; rsp_valid && rsp_fault |-> !$past(io.valid); endproperty
    a_fault_no_io: assert property (p_fault_no_io) else $error("faulted op reached bus");
    property p_fetch_pulse; tss_rd_req |=> !tss_rd_req; endproperty
    a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch longer than a pulse");
    property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside its cycle");
    c_fault: cover property (rsp_valid && rsp_fault);
    c_fetch: cover property (tss_rd_req);
    c_io_wr: cover property (io_done && io.write);
endmodule

bind ipac_checker ipac_checker_assertions u_sva (.clock(clock), .arst_n(arst_n),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_fault(rsp_fault),
    .store_pending(store_pending), .tss_rd_req(tss_rd_req), .io(io), .io_done(io_done),
    .irq_enable(irq_enable));

// >>> ipac_far_model.sv
// Far side model: port bus decoder and task segment bitmap memory
module ipac_far_model
    import ipac_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic arst_n, // Async reset, active low
    input wire logic slow, // Stretch every answer
    input wire ipac_io_t io, // Port cycle
    input wire logic tss_rd_req, // Bitmap fetch
    input wire logic [31:0] tss_rd_addr, // Bitmap byte offset
    output logic io_done, // Port cycle finished
    output logic [31:0] io_rdata, // Port read data
    output logic tss_rd_valid, // Bitmap bytes back
    output logic [15:0] tss_rd_data // Two bitmap bytes
);
    // ----------------------------------------
    // Answer logic
    // ----------------------------------------
    logic [7:0] map_mem [0:31];
    logic [3:0] io_cnt, t_cnt;
    logic io_busy, t_busy;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {io_done, io_busy, t_busy, tss_rd_valid} <= 4'h0;
            {io_cnt, t_cnt, io_rdata, tss_rd_data} <= '0;
        end else begin
            io_done <= 1'b0;
            tss_rd_valid <= 1'b0;
            // Idle lines toggle so a stale value never looks valid
            io_rdata <= ~io_rdata;
            tss_rd_data <= ~tss_rd_data;
            if (io.valid && !io_busy && !io_done) begin
                io_busy <= 1'b1;
                io_cnt <= slow ? 4'h4 : 4'h0;
            end else if (io_busy && io_cnt != 4'h0) begin
                io_cnt <= io_cnt - 4'h1;
            end else if (io_busy) begin
                io_busy <= 1'b0;
                io_done <= 1'b1;
                io_rdata <= {16'hD00D, io.addr};
            end
            if (tss_rd_req) begin
                t_busy <= 1'b1;
                t_cnt <= slow ? 4'h3 : 4'h0;
            end else if (t_busy && t_cnt != 4'h0) begin
                t_cnt <= t_cnt - 4'h1;
            end else if (t_busy) begin
                t_busy <= 1'b0;
                tss_rd_valid <= 1'b1;
                tss_rd_data <= {map_mem[tss_rd_addr[4:0] + 5'h1], map_mem[tss_rd_addr[4:0]]};
            end
        end
    end
endmodule

// >>> ipac_checker_bench.sv
// Self-checking bench for the port access checker
`include "ipac_defines.svh"
module ipac_checker_bench
    import ipac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
    logic store_pending = 1'b0, slow = 1'b0, unc = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rsp_rdata, tss_rd_addr, io_rdata;
    logic req_ready, rsp_valid, rsp_fault, tss_rd_req, tss_rd_valid, io_done;
    logic irq_enable, legacy_mode;
    logic [15:0] tss_rd_data;
    ipac_req_t req = '0;
    ipac_io_t io, seen;
    int fails = 0, n_tests = 0;

    ipac_checker uut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_fault(rsp_fault), .rsp_rdata(rsp_rdata), .store_pending(store_pending),
        .tss_rd_req(tss_rd_req), .tss_rd_addr(tss_rd_addr), .tss_rd_valid(tss_rd_valid),
        .tss_rd_data(tss_rd_data), .io(io), .io_done(io_done), .io_rdata(io_rdata),
        .irq_enable(irq_enable), .legacy_mode(legacy_mode));
    ipac_far_model u_far (.clock(clock), .arst_n(arst_n), .slow(slow), .io(io),
        .tss_rd_req(tss_rd_req), .tss_rd_addr(tss_rd_addr), .io_done(io_done),
        .io_rdata(io_rdata), .tss_rd_valid(tss_rd_valid), .tss_rd_data(tss_rd_data));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(string nm, logic [31:0] s, logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clock); reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clock); reg_rd <= 1'b0;
        @(negedge clock); check("reg_rdata", reg_rdata, e);
        @(posedge clock);
    endtask
    // Bus fields are only compared when the op was expected to pass
    task automatic op(ipac_op_t o, logic [15:0] p, ipac_width_t w, logic [31:0] fv, logic xf);
        int n;
        seen = '0;
        req_valid <= 1'b1;
        req <= '{o, p, w, {16'h5A00, p}, fv, unc};
        #1;
        while (req_ready !== 1'b1) begin @(posedge clock); #1; end
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin @(posedge clock); #1; if (io.valid === 1'b1) seen = io; n++; end
        while (rsp_valid !== 1'b1 && n < 300);
        check("rsp_valid", {31'h0, rsp_valid}, 32'h1);
        check("rsp_fault", {31'h0, rsp_fault}, {31'h0, xf});
        if (o <= IPAC_OP_PORT_WR_STR && !xf) begin
            check("io_addr", {16'h0, seen.addr}, {16'h0, p});
            check("io_width", {30'h0, seen.width}, {30'h0, w});
            check("io_write", {31'h0, seen.write}, {31'h0, o >= IPAC_OP_PORT_WR});
            if (o <= IPAC_OP_PORT_RD_STR) begin
                check("rsp_rdata", rsp_rdata, {16'hD00D, p});
            end else begin
                check("io_wdata", seen.wdata, {16'h5A00, p});
            end
        end else begin
            check("io_valid", {31'h0, seen.valid}, 32'h0);
        end
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial forever #10 clock = ~clock;
    initial begin #100000; fails++; close_out(); end
    initial begin
        // Map at offset 10H, limit 1AH: ports 0..4FH mapped, 29H denied
        for (int i = 0; i < 32; i++) u_far.map_mem[i] = 8'h00;
        u_far.map_mem[21] = 8'h02;
        u_far.map_mem[26] = `IPAC_BYTE_ONES;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd(`IPAC_REG_FLAGS, `IPAC_FLAGS_RESET);
        rd(`IPAC_REG_MAP_BASE, {16'h0, `IPAC_BASE_RESET});
        rd(`IPAC_REG_SEG_LIMIT, `IPAC_LIMIT_RESET);
        rd(8'h20, 32'h0);
        op(IPAC_OP_PORT_WR, 16'h0080, IPAC_W4, 32'h2, 1'b0);
        store_pending <= 1'b1;
        fork
            op(IPAC_OP_PORT_WR, 16'h0081, IPAC_W2, 32'h2, 1'b0);
            begin
                repeat (8) @(posedge clock);
                #1 check("io_valid", {31'h0, io.valid}, 32'h0);
                store_pending <= 1'b0;
            end
        join
        slow <= 1'b1;
        op(IPAC_OP_PORT_RD, 16'hFFFC, IPAC_W4, 32'h2, 1'b0);
        wr(`IPAC_REG_CPL, 32'h3);
        op(IPAC_OP_PORT_RD, 16'h0028, IPAC_W1, 32'h2, 1'b1);
        wr(`IPAC_REG_MAP_BASE, 32'h10);
        wr(`IPAC_REG_SEG_LIMIT, 32'h1A);
        op(IPAC_OP_PORT_RD, 16'h0029, IPAC_W1, 32'h2, 1'b1);
        op(IPAC_OP_PORT_RD_STR, 16'h0028, IPAC_W1, 32'h2, 1'b0);
        op(IPAC_OP_PORT_WR, 16'h0025, IPAC_W4, 32'h2, 1'b0);
        op(IPAC_OP_PORT_WR_STR, 16'h0026, IPAC_W4, 32'h2, 1'b1);
        op(IPAC_OP_PORT_RD, 16'h002F, IPAC_W2, 32'h2, 1'b0);
        op(IPAC_OP_PORT_RD, 16'h004F, IPAC_W1, 32'h2, 1'b0);
        op(IPAC_OP_PORT_RD, 16'h004F, IPAC_W2, 32'h2, 1'b1);
        op(IPAC_OP_PORT_RD, 16'h0058, IPAC_W1, 32'h2, 1'b1);
        op(IPAC_OP_IRQ_MASK, 16'h0, IPAC_W1, 32'h2, 1'b1);
        op(IPAC_OP_IRQ_UNMASK, 16'h0, IPAC_W1, 32'h2, 1'b1);
        op(IPAC_OP_FLAGS_POP, 16'h0, IPAC_W1, 32'h3202, 1'b0);
        rd(`IPAC_REG_FLAGS, 32'h0000_0002);
        wr(`IPAC_REG_CPL, 32'h0);
        wr(`IPAC_REG_CTRL, 32'h1);
        check("legacy_mode", {31'h0, legacy_mode}, 32'h1);
        op(IPAC_OP_PORT_RD, 16'h0029, IPAC_W1, 32'h2, 1'b1);
        wr(`IPAC_REG_CTRL, 32'h0);
        op(IPAC_OP_TRAP_RET, 16'h0, IPAC_W1, 32'h3202, 1'b0);
        rd(`IPAC_REG_FLAGS, 32'h0000_3202);
        check("irq_enable", {31'h0, irq_enable}, 32'h1);
        wr(`IPAC_REG_CPL, 32'h3);
        op(IPAC_OP_PORT_RD, 16'h0029, IPAC_W1, 32'h2, 1'b0);
        op(IPAC_OP_IRQ_MASK, 16'h0, IPAC_W1, 32'h2, 1'b0);
        check("irq_enable", {31'h0, irq_enable}, 32'h0);
        op(IPAC_OP_FLAGS_POP, 16'h0, IPAC_W1, 32'h0202, 1'b0);
        rd(`IPAC_REG_FLAGS, 32'h0000_3202);
        op(IPAC_OP_TRAP_RET, 16'h0, IPAC_W1, 32'h0002, 1'b0);
        rd(`IPAC_REG_FLAGS, 32'h0000_3002);
        op(IPAC_OP_MEM_WR, 16'h0, IPAC_W1, 32'h2, 1'b0);
        // Cacheable read answers at once although stores are pending
        store_pending <= 1'b1;
        op(IPAC_OP_MEM_RD, 16'h0, IPAC_W1, 32'h2, 1'b0);
        // Ordered software marks the region uncacheable; read must wait
        unc = 1'b1;
        fork
            op(IPAC_OP_MEM_RD, 16'h0, IPAC_W1, 32'h2, 1'b0);
            begin
                repeat (6) @(posedge clock);
                #1 check("req_ready", {31'h0, req_ready}, 32'h0);
                store_pending <= 1'b0;
            end
        join
        unc = 1'b0;
        rd(`IPAC_REG_STATUS, 32'h0008_0000);
        close_out();
    end
endmodule
